// *** hdl/cpeqc_ctrl.sv ***
// Crosspoint lane mapping and receiver equalization control
//
// Behaviour
// - Config from straps or registers per mode
// - Register mode ignores equalization strap pins
// - Both address straps floating gives address 0x12
// - Upstream and display gain from pins or registers
// - Fixed mode applies one unchanging receiver gain
// - Fast adaptive picks short or long preset
// - Fast adaptive works in both control modes
// - Register fast adaptive: style 0, enable 1
// - Short channel uses short gain registers
// - Long channel uses long gain registers
// - Full adaptive tracks best gain continuously
// - Full adaptive disabled after reset
// - Full adaptive: style 1, enable 1 or 3
// - Select hi low, lo high: USB only
// - Both selects high: USB plus two display
// - Select hi high, lo low: four display
// - Orientation pin high selects mirrored mapping
`timescale 1ns/1ps
module cpeqc_ctrl (
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic NRST_I,
  // Lane mapping pins
  input wire logic MODE_SELECT_HI_I,
  input wire logic MODE_SELECT_LO_I,
  input wire logic FLIP_I,
  // Control-mode strap, sensed level code
  input wire logic [1:0] CTRL_MODE_LVL_I,
  // Equalization strap pairs, sensed level codes, index 1 is the high pin
  input wire logic [1:0][1:0] UPSTREAM_USB_GAIN_PINS_I,
  input wire logic [1:0][1:0] DISPLAY_GAIN_PINS_I,
  input wire logic [1:0][1:0] DOWNSTREAM_RX_GAIN_PINS_I,
  // Fast adaptive enable strap for pin mode
  input wire logic FAST_ADAPT_PIN_I,
  // Register image from the serial target port, same clock
  input wire cpeqc_pkg::cpeqc_regs_t REG_CFG_I,
  // Analog channel detectors, one bit per downstream receiver
  input wire logic [1:0] RX_LONG_CHAN_I,
  input wire logic [1:0] RX_NEED_MORE_I,
  input wire logic [1:0] RX_NEED_LESS_I,
  // Configuration results
  output logic [6:0] TARGET_ADDR_O,
  output logic REG_MODE_O,
  output logic CFG_READY_O,
  output cpeqc_pkg::cpeqc_lane_t LANE_MODE_O,
  output logic FLIPPED_O,
  output cpeqc_pkg::cpeqc_eq_t EQ_O,
  output logic FAST_AEQ_O,
  output logic FULL_AEQ_O
);

  localparam int SYNC_W = 24;

  // Synchronised pin view
  logic [SYNC_W-1:0] pins_raw; // Concatenated async pins
  logic [SYNC_W-1:0] pins; // Filtered pin values
  logic sel_hi; // Mode select high
  logic sel_lo; // Mode select low
  logic flip; // Orientation
  logic fast_pin; // Fast adaptive strap
  logic [1:0] mode_lvl; // Control-mode strap level
  logic [1:0][1:0] usb_pins; // Upstream USB gain straps
  logic [1:0][1:0] dp_pins; // Display gain straps
  logic [1:0][1:0] rx_pins; // Downstream gain straps
  logic [1:0] rx_long; // Long channel seen
  logic [1:0] need_more; // Full adaptive asks for more gain
  logic [1:0] need_less; // Full adaptive asks for less gain

  assign pins_raw = {MODE_SELECT_HI_I, MODE_SELECT_LO_I, FLIP_I,
                     FAST_ADAPT_PIN_I, CTRL_MODE_LVL_I,
                     UPSTREAM_USB_GAIN_PINS_I, DISPLAY_GAIN_PINS_I,
                     DOWNSTREAM_RX_GAIN_PINS_I, RX_LONG_CHAN_I,
                     RX_NEED_MORE_I, RX_NEED_LESS_I};
  assign {sel_hi, sel_lo, flip, fast_pin, mode_lvl, usb_pins, dp_pins,
          rx_pins, rx_long, need_more, need_less} = pins;

  // All pins come from outside the clock domain
  cpeqc_sync #(
    .W(SYNC_W)
  ) u_sync (
    .clk(REF_CLK_I),
    .nrst(NRST_I),
    .async_i(pins_raw),
    .sync_o(pins)
  );

  // Strap capture sequencer
  cpeqc_pkg::cpeqc_state_t state; // Current step
  logic [7:0] settle_cnt; // Cycles waited since release

  // Wait for the synchronisers to fill before trusting strap levels
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state <= cpeqc_pkg::ST_SETTLE;
      settle_cnt <= 8'h00;
    end else begin
      case (state)
        cpeqc_pkg::ST_SETTLE: begin
          if (settle_cnt == 8'(cpeqc_pkg::SETTLE_CYC - 1)) begin
            state <= cpeqc_pkg::ST_LATCH;
          end else begin
            settle_cnt <= settle_cnt + 8'h01;
          end
        end
        cpeqc_pkg::ST_LATCH: begin
          state <= cpeqc_pkg::ST_RUN;
        end
        cpeqc_pkg::ST_RUN: begin
          state <= cpeqc_pkg::ST_RUN;
        end
        default: begin
          state <= cpeqc_pkg::ST_SETTLE;
        end
      endcase
    end
  end

  // Address derived from the two shared address straps
  function automatic logic [6:0] strap_addr(input logic [1:0] a1,
                                            input logic [1:0] a0);
    if (a1 == cpeqc_pkg::LVL_FLOAT && a0 == cpeqc_pkg::LVL_FLOAT) begin
      return cpeqc_pkg::ADDR_FLOAT;
    end
    return 7'(cpeqc_pkg::ADDR_ALT_BASE + 7'(cpeqc_pkg::lvl_num(a1) * 4'h3)
              + 7'(cpeqc_pkg::lvl_num(a0)));
  endfunction : strap_addr

  // Mode and address are caught once, after release and settling;
  // a strap moved later has no effect until the next reset
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      REG_MODE_O <= 1'b0;
      TARGET_ADDR_O <= cpeqc_pkg::ADDR_RST;
      CFG_READY_O <= 1'b0;
    end else if (state == cpeqc_pkg::ST_LATCH) begin
      // Any level but low selects register control
      REG_MODE_O <= (mode_lvl != cpeqc_pkg::LVL_LOW);
      TARGET_ADDR_O <= strap_addr(dp_pins[0], usb_pins[0]);
      CFG_READY_O <= 1'b1;
    end
  end

  // Adaptive style decode
  logic fast_req; // Fast adaptive requested
  logic full_req; // Full adaptive requested
  always_comb begin
    fast_req = 1'b0;
    full_req = 1'b0;
    if (REG_MODE_O) begin
      fast_req = (REG_CFG_I.adaptive_style == cpeqc_pkg::AEQ_STYLE_FAST) &&
                 (REG_CFG_I.adaptive_on == cpeqc_pkg::AEQ_ON_FAST);
      full_req = (REG_CFG_I.adaptive_style == cpeqc_pkg::AEQ_STYLE_FULL) &&
                 ((REG_CFG_I.adaptive_on == cpeqc_pkg::AEQ_ON_FULL_A) ||
                  (REG_CFG_I.adaptive_on == cpeqc_pkg::AEQ_ON_FULL_B));
    end else begin
      // Pin control offers fast adaptive through its own strap
      fast_req = fast_pin;
    end
  end

  // Mode flags register; full adaptive stays off until fully ready
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      FAST_AEQ_O <= 1'b0;
      FULL_AEQ_O <= 1'b0;
    end else begin
      FAST_AEQ_O <= CFG_READY_O && fast_req;
      FULL_AEQ_O <= CFG_READY_O && full_req;
    end
  end

  // Lane mapping decode
  function automatic cpeqc_pkg::cpeqc_lane_t lane_of(input logic hi,
                                                     input logic lo);
    if (!hi && lo) begin
      return cpeqc_pkg::LANE_USB;
    end else if (hi && lo) begin
      return cpeqc_pkg::LANE_USB_DP2;
    end else if (hi && !lo) begin
      return cpeqc_pkg::LANE_DP4;
    end
    return cpeqc_pkg::LANE_OFF;
  endfunction : lane_of

  // Lane mapping follows the select pins live, in either control mode
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      LANE_MODE_O <= cpeqc_pkg::LANE_OFF;
      FLIPPED_O <= 1'b0;
    end else begin
      LANE_MODE_O <= lane_of(sel_hi, sel_lo);
      FLIPPED_O <= flip;
    end
  end

  // Fixed receiver gains, from straps or the short registers
  logic [3:0] rx1_fixed; // Receiver one base gain
  logic [3:0] rx2_fixed; // Receiver two base gain
  logic [3:0] rx1_long_g; // Receiver one long preset
  logic [3:0] rx2_long_g; // Receiver two long preset
  always_comb begin
    if (REG_MODE_O) begin
      // Straps are not looked at, so they may float
      rx1_fixed = REG_CFG_I.rx_one_short_gain;
      rx2_fixed = REG_CFG_I.rx_two_short_gain;
      rx1_long_g = REG_CFG_I.rx_one_long_gain;
      rx2_long_g = REG_CFG_I.rx_two_long_gain;
    end else begin
      rx1_fixed = cpeqc_pkg::pin_pair_gain(rx_pins[1], rx_pins[0]);
      rx2_fixed = rx1_fixed;
      // Pin mode has no long register; long preset is the maximum gain, GAIN_MAX
      rx1_long_g = cpeqc_pkg::GAIN_MAX;
      rx2_long_g = cpeqc_pkg::GAIN_MAX;
    end
  end

  // Full adaptive step timer
  logic [7:0] step_cnt; // Cycles since last step
  logic step; // One-cycle update strobe
  assign step = (step_cnt == 8'(cpeqc_pkg::STEP_CYC - 1));

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      step_cnt <= 8'h00;
    end else if (!FULL_AEQ_O || step) begin
      step_cnt <= 8'h00;
    end else begin
      step_cnt <= step_cnt + 8'h01;
    end
  end

  // One gain tracking step toward the detector's request
  function automatic logic [3:0] track(input logic [3:0] g,
                                       input logic more,
                                       input logic less);
    if (more && !less && g != cpeqc_pkg::GAIN_MAX) begin
      return g + 4'h1;
    end else if (less && !more && g != cpeqc_pkg::GAIN_MIN) begin
      return g - 4'h1;
    end
    return g;
  endfunction : track

  // Applied gains, one flop set per process so each has a single driver
  logic [3:0] rx1_gain; // Receiver one applied gain
  logic [3:0] rx2_gain; // Receiver two applied gain
  logic [3:0] usb_gain; // Upstream USB applied gain
  logic [3:0][3:0] dp_gain; // Display lane applied gains
  assign EQ_O = {usb_gain, dp_gain, rx1_gain, rx2_gain};

  // Receiver gains; full adaptive starts from the gain last applied then walks
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rx1_gain <= cpeqc_pkg::GAIN_RST;
      rx2_gain <= cpeqc_pkg::GAIN_RST;
    end else if (FULL_AEQ_O) begin
      if (step) begin
        // Any channel length: no preset, only the detector decides
        rx1_gain <= track(rx1_gain, need_more[0],
                          need_less[0]);
        rx2_gain <= track(rx2_gain, need_more[1],
                          need_less[1]);
      end
    end else if (FAST_AEQ_O) begin
      // Classified per receiver, short or long preset
      rx1_gain <= rx_long[0] ? rx1_long_g : rx1_fixed;
      rx2_gain <= rx_long[1] ? rx2_long_g : rx2_fixed;
    end else begin
      rx1_gain <= rx1_fixed;
      rx2_gain <= rx2_fixed;
    end
  end

  // Upstream USB and display gains
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      usb_gain <= cpeqc_pkg::GAIN_RST;
      dp_gain <= '0;
    end else if (REG_MODE_O) begin
      usb_gain <= REG_CFG_I.upstream_usb_gain_reg;
      dp_gain <= REG_CFG_I.display_lane_gain_reg;
    end else begin
      usb_gain <= cpeqc_pkg::pin_pair_gain(usb_pins[1],
                                           usb_pins[0]);
      // One pin pair serves all four display lanes
      for (int i = 0; i < 4; i++) begin
        dp_gain[i] <= cpeqc_pkg::pin_pair_gain(dp_pins[1],
                                               dp_pins[0]);
      end
    end
  end

  // Checks

  sequence full_fields_s;
    REG_MODE_O && REG_CFG_I.adaptive_style &&
      (REG_CFG_I.adaptive_on == 2'h1 || REG_CFG_I.adaptive_on == 2'h3);
  endsequence

  sequence fast_fields_s;
    REG_MODE_O && !REG_CFG_I.adaptive_style &&
      (REG_CFG_I.adaptive_on == 2'h1);
  endsequence

  addr_float_a: assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    (state == cpeqc_pkg::ST_LATCH && dp_pins[0] == 2'h1 &&
     usb_pins[0] == 2'h1) |=> (TARGET_ADDR_O == 7'h12))
    else $error("address not 0x12 with floating straps");

  reg_mode_a: assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    (state == cpeqc_pkg::ST_LATCH) |=>
      (REG_MODE_O == ($past(mode_lvl) != 2'h0)) && CFG_READY_O)
    else $error("control mode latched wrong");

  full_on_a: assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    (full_fields_s and CFG_READY_O) |=> FULL_AEQ_O)
    else $error("full adaptive not enabled");

  full_off_a: assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    !CFG_READY_O |-> !FULL_AEQ_O)
    else $error("full adaptive on before ready");

  fast_on_a: assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    (fast_fields_s and CFG_READY_O) |=> FAST_AEQ_O && !FULL_AEQ_O)
    else $error("fast adaptive not enabled");

  long_sel_a: assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    (FAST_AEQ_O && !FULL_AEQ_O && REG_MODE_O && rx_long[0]) |=>
      (EQ_O.rx_one_gain == $past(REG_CFG_I.rx_one_long_gain)))
    else $error("long preset not applied");

  short_sel_a: assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    (FAST_AEQ_O && !FULL_AEQ_O && REG_MODE_O && !rx_long[1]) |=>
      (EQ_O.rx_two_gain == $past(REG_CFG_I.rx_two_short_gain)))
    else $error("short preset not applied");

  lane_map_a: assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    (sel_hi && sel_lo) |=> (LANE_MODE_O == cpeqc_pkg::LANE_USB_DP2))
    else $error("usb plus two display not selected");

  lane_dp4_a: assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    (sel_hi && !sel_lo) |=> (LANE_MODE_O == cpeqc_pkg::LANE_DP4))
    else $error("four display not selected");

  flip_map_a: assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    ##1 (FLIPPED_O == $past(flip)))
    else $error("orientation not followed");

  track_step_a: assert property (
    @(posedge REF_CLK_I) disable iff (!NRST_I)
    (FULL_AEQ_O && $past(FULL_AEQ_O) && !step) |=>
      $stable(EQ_O.rx_one_gain))
    else $error("full adaptive gain moved off step");

endmodule : cpeqc_ctrl

// *** hdl/cpeqc_pkg.sv ***
// Package: types and constants for the crosspoint equalizer config block
package cpeqc_pkg;

  // Clock rate and derived cycle counts
  localparam int CLK_MHZ = 50;
  // Strap settle time after reset release, least time, rounds up
  localparam int SETTLE_NS = 200;
  localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  // Full adaptive update interval, rounds down
  localparam int STEP_NS = 1000;
  localparam int STEP_CYC = (STEP_NS * CLK_MHZ) / 1000;

  // Sensed strap levels: low, floating, high
  localparam logic [1:0] LVL_LOW = 2'h0;
  localparam logic [1:0] LVL_FLOAT = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h3;

  // Target addresses
  localparam logic [6:0] ADDR_FLOAT = 7'h12;
  localparam logic [6:0] ADDR_ALT_BASE = 7'h20;
  localparam logic [6:0] ADDR_RST = 7'h00;

  // Adaptive field encodings
  localparam logic AEQ_STYLE_FAST = 1'h0;
  localparam logic AEQ_STYLE_FULL = 1'h1;
  localparam logic [1:0] AEQ_ON_FAST = 2'h1;
  localparam logic [1:0] AEQ_ON_FULL_A = 2'h1;
  localparam logic [1:0] AEQ_ON_FULL_B = 2'h3;

  // Gain limits and reset value
  localparam logic [3:0] GAIN_MAX = 4'hF;
  localparam logic [3:0] GAIN_MIN = 4'h0;
  localparam logic [3:0] GAIN_RST = 4'h0;

  // Lane mapping modes, one-hot
  typedef enum logic [3:0] {
    LANE_OFF = 4'h1,
    LANE_USB = 4'h2,
    LANE_USB_DP2 = 4'h4,
    LANE_DP4 = 4'h8
  } cpeqc_lane_t;

  // Strap capture sequencer, one-hot
  typedef enum logic [2:0] {
    ST_SETTLE = 3'h1,
    ST_LATCH = 3'h2,
    ST_RUN = 3'h4
  } cpeqc_state_t;

  // Register-file image written by the serial target port
  typedef struct packed {
    logic [3:0] upstream_usb_gain_reg;
    logic [3:0][3:0] display_lane_gain_reg;
    logic [3:0] rx_one_short_gain;
    logic [3:0] rx_two_short_gain;
    logic [3:0] rx_one_long_gain;
    logic [3:0] rx_two_long_gain;
    logic adaptive_style;
    logic [1:0] adaptive_on;
  } cpeqc_regs_t;

  // Gains applied to the analog receivers
  typedef struct packed {
    logic [3:0] usb_gain;
    logic [3:0][3:0] dp_gain;
    logic [3:0] rx_one_gain;
    logic [3:0] rx_two_gain;
  } cpeqc_eq_t;

  // Numeric weight of a sensed level: 0, 1 or 2
  function automatic logic [3:0] lvl_num(input logic [1:0] lvl);
    if (lvl == LVL_HIGH) begin
      return 4'h2;
    end else if (lvl == LVL_FLOAT) begin
      return 4'h1;
    end
    return 4'h0;
  endfunction : lvl_num

  // Map a strap pin pair to a gain code, 0 to 14
  function automatic logic [3:0] pin_pair_gain(input logic [1:0] hi,
                                               input logic [1:0] lo);
    return 4'((lvl_num(hi) * 4'h5) + (lvl_num(lo) * 4'h2));
  endfunction : pin_pair_gain

endpackage : cpeqc_pkg

// *** hdl/cpeqc_sync.sv ***
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module cpeqc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Asynchronous input and filtered output
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] stage1; // Metastability catcher, read only by stage2
  logic [W-1:0] stage2; // Second stage
  logic [W-1:0] stage3; // Third stage

  // Shift chain
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= async_i;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // A change counts only once stages two and three agree, per bit
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync_o <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (stage2[i] == stage3[i]) begin
          sync_o[i] <= stage3[i];
        end
      end
    end
  end

endmodule : cpeqc_sync

// *** dv/cpeqc_pd_model.sv ***
// Power-delivery controller model: register image and control-mode strap
`timescale 1ns/1ps
module cpeqc_pd_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Commands from the bench
  input wire logic wr_i,
  input wire cpeqc_pkg::cpeqc_regs_t wdata_i,
  input wire logic reg_sel_i,
  // Device-facing side
  output logic [1:0] ctrl_lvl_o,
  output cpeqc_pkg::cpeqc_regs_t regs_o
);
  // Strap pulled high asks for register control, tied low keeps pins
  assign ctrl_lvl_o = reg_sel_i ? cpeqc_pkg::LVL_HIGH :
                      cpeqc_pkg::LVL_LOW;

  // Register image, cleared with the device so no adaptive mode is armed
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      regs_o <= '0;
    end else if (wr_i) begin
      // One whole image per write, as a finished transaction lands
      regs_o <= wdata_i;
    end
  end
endmodule : cpeqc_pd_model

// *** dv/crosspoint_eq_config_ctrl_tb_top.sv ***
// Self-checking bench for the crosspoint equalizer config block
`timescale 1ns/1ps
module crosspoint_eq_config_ctrl_tb_top;
  // Clock, reset and pins; address straps start floating
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic hi = 1'b0, lo = 1'b0, flip = 1'b0, fpin = 1'b0, wr = 1'b0;
  logic rsel = 1'b1;
  logic [1:0][1:0] upin = 4'h1, dpin = 4'h1, rpin = 4'h0;
  logic [1:0] lng = 2'h0, more = 2'h0, less = 2'h0, lvl;
  cpeqc_pkg::cpeqc_regs_t w = '0, m, v, regs;
  // Design results and the expected gains
  logic [6:0] addr;
  logic rmode, ready, flipped, fast, full;
  cpeqc_pkg::cpeqc_lane_t lane;
  cpeqc_pkg::cpeqc_eq_t eq, ex;
  logic [31:0] seed = 32'h2A52;
  int error_cnt = 0, total_checks = 0, n;

  always #10 clk = ~clk;

  cpeqc_pd_model PD (.clk_i(clk), .nrst_i(nrst), .wr_i(wr), .wdata_i(w),
    .reg_sel_i(rsel), .ctrl_lvl_o(lvl), .regs_o(regs));

  cpeqc_ctrl DUT (.REF_CLK_I(clk), .NRST_I(nrst), .MODE_SELECT_HI_I(hi),
    .MODE_SELECT_LO_I(lo), .FLIP_I(flip), .CTRL_MODE_LVL_I(lvl),
    .UPSTREAM_USB_GAIN_PINS_I(upin), .DISPLAY_GAIN_PINS_I(dpin),
    .DOWNSTREAM_RX_GAIN_PINS_I(rpin), .FAST_ADAPT_PIN_I(fpin),
    .REG_CFG_I(regs), .RX_LONG_CHAN_I(lng), .RX_NEED_MORE_I(more),
    .RX_NEED_LESS_I(less), .TARGET_ADDR_O(addr), .REG_MODE_O(rmode),
    .CFG_READY_O(ready), .LANE_MODE_O(lane), .FLIPPED_O(flipped),
    .EQ_O(eq), .FAST_AEQ_O(fast), .FULL_AEQ_O(full));

  // Shift register source, fixed start so runs repeat
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd

  // Random sensed level: low, floating or high, never the unused code
  function automatic logic [1:0] rlvl();
    logic [1:0] t;
    t = 2'(rnd() % 3);
    return (t == 2'h2) ? 2'h3 : t;
  endfunction : rlvl

  // Weight of a level and gain of a pin pair
  function automatic int lv(input logic [1:0] c);
    return (c == 2'h3) ? 2 : int'(c);
  endfunction : lv

  function automatic logic [3:0] pg(input logic [1:0][1:0] p);
    return 4'(5 * lv(p[1]) + 2 * lv(p[0]));
  endfunction : pg

  // Lane mapping expected from the two select pins
  function automatic cpeqc_pkg::cpeqc_lane_t xlane(input bit h, input bit l);
    if (h && !l) begin
      return cpeqc_pkg::LANE_DP4;
    end else if (h) begin
      return cpeqc_pkg::LANE_USB_DP2;
    end
    return l ? cpeqc_pkg::LANE_USB : cpeqc_pkg::LANE_OFF;
  endfunction : xlane

  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
  endtask : cyc

  // Scalar compare
  task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_v

  // Gain bundle compare
  task automatic chk_eq(input cpeqc_pkg::cpeqc_eq_t got,
                        input cpeqc_pkg::cpeqc_eq_t exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_eq

  // Write an image through the controller model, then let it settle
  task automatic put(input cpeqc_pkg::cpeqc_regs_t x);
    m = x;
    w <= x;
    wr <= 1'b1;
    cyc(1);
    wr <= 1'b0;
    cyc(6);
  endtask : put

  // Reference model of the applied gains
  task automatic model(input bit regm, input bit fm);
    if (regm) begin
      ex.usb_gain = m.upstream_usb_gain_reg;
      ex.dp_gain = m.display_lane_gain_reg;
      ex.rx_one_gain = (fm && lng[0]) ? m.rx_one_long_gain :
                       m.rx_one_short_gain;
      ex.rx_two_gain = (fm && lng[1]) ? m.rx_two_long_gain :
                       m.rx_two_short_gain;
    end else begin
      // Pin mode: one display pair feeds all four lanes
      ex.usb_gain = pg(upin);
      for (int i = 0; i < 4; i++) begin
        ex.dp_gain[i] = pg(dpin);
      end
      ex.rx_one_gain = (fm && lng[0]) ? 4'hF : pg(rpin);
      ex.rx_two_gain = (fm && lng[1]) ? 4'hF : pg(rpin);
    end
  endtask : model

  // Pulse reset; straps are already steady
  task automatic do_reset();
    nrst <= 1'b0;
    cyc(2);
    chk_v(lane, cpeqc_pkg::LANE_OFF);
    nrst <= 1'b1;
    m = '0;
    cyc(14);
  endtask : do_reset

  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    cyc(20);
    chk_v(lane, cpeqc_pkg::LANE_OFF);
    nrst <= 1'b1;
    cyc(14);
    chk_v(rmode, 1'b1);
    chk_v(addr, 7'h12);
    chk_v(ready, 1'b1);
    chk_v(full, 1'b0);
    $display("test register straps done");
    // Every select and orientation combination
    for (int i = 0; i < 8; i++) begin
      hi <= i[2];
      lo <= i[1];
      flip <= i[0];
      cyc(7);
      chk_v(lane, xlane(i[2], i[1]));
      chk_v(flipped, i[0]);
    end
    $display("test lanes done");
    // Every adaptive code; downstream gain straps wiggle and must be ignored
    for (int k = 0; k < 8; k++) begin
      v = 39'({rnd(), rnd()});
      v.adaptive_style = k[2];
      v.adaptive_on = 2'(k);
      lng <= 2'(rnd());
      rpin <= {rlvl(), rlvl()};
      put(v);
      chk_v(fast, !k[2] && k[1:0] == 2'h1);
      chk_v(full, k[2] && k[0]);
      model(1'b1, !k[2] && k[1:0] == 2'h1);
      if (!(k[2] && k[0])) begin
        chk_eq(eq, ex);
      end
    end
    $display("test register gains done");
    // Full adaptive: one step up on receiver one, down on receiver two
    v.adaptive_style = 1'b0;
    v.adaptive_on = 2'h0;
    v.rx_one_short_gain = 4'(rnd() % 15);
    v.rx_two_short_gain = 4'(rnd() % 15 + 1);
    put(v);
    v.adaptive_style = 1'b1;
    v.adaptive_on = 2'h3;
    put(v);
    more <= 2'h1;
    less <= 2'h2;
    n = 0;
    while (eq.rx_one_gain === v.rx_one_short_gain && n < 120) begin
      cyc(1);
      n++;
    end
    if (n == 120) begin
      error_cnt++;
      report_and_stop();
    end
    more <= 2'h0;
    less <= 2'h0;
    model(1'b1, 1'b0);
    ex.rx_one_gain = v.rx_one_short_gain + 4'h1;
    ex.rx_two_gain = v.rx_two_short_gain - 4'h1;
    cyc(2);
    chk_eq(eq, ex);
    $display("test full adaptive done");
    // Pin control with random straps
    rsel <= 1'b0;
    upin <= {rlvl(), rlvl()};
    dpin <= {rlvl(), rlvl()};
    rpin <= {rlvl(), rlvl()};
    do_reset();
    chk_v(rmode, 1'b0);
    chk_v(addr, (dpin[0] == 2'h1 && upin[0] == 2'h1) ? 7'h12 :
          7'(32 + 3 * lv(dpin[0]) + lv(upin[0])));
    v = 39'({rnd(), rnd()});
    v.adaptive_style = 1'b0;
    v.adaptive_on = 2'h0;
    put(v);
    for (int k = 0; k < 4; k++) begin
      fpin <= k[1];
      lng <= 2'(rnd());
      cyc(7);
      model(1'b0, k[1]);
      chk_v(fast, k[1]);
      chk_eq(eq, ex);
    end
    $display("test pin mode done");
    report_and_stop();
  end
endmodule : crosspoint_eq_config_ctrl_tb_top
